// *** core/dcbr_pkg.sv ***
// dcbr_pkg: sizes, reset values and request carriers of the
// two-port block memory.
// assumes: imported whole by every design file of the block.
package dcbr_pkg;

	////////////////////////////////////////////////////////////////////
	// array geometry
	localparam int DCBR_DEPTH = 256;
	localparam int DCBR_AW    = 8;
	localparam int DCBR_DW    = 16;

	////////////////////////////////////////////////////////////////////
	// values after reset and special locations
	localparam logic [DCBR_DW-1:0] DCBR_RD_DATA_RST = 16'h0000;
	localparam logic [DCBR_AW-1:0] DCBR_NO_INIT_LOC = 8'h00;
	localparam logic               DCBR_BIT_RST     = 1'h0;

	////////////////////////////////////////////////////////////////////
	// request carriers
	typedef struct packed {
		logic [DCBR_AW-1:0] wr_location;
		logic [DCBR_DW-1:0] wr_data;
		logic [DCBR_DW-1:0] wr_mask;
		logic               wr_port_enable;
		logic               wr_clock_gate;
	} dcbr_wr_req_t;

	typedef struct packed {
		logic [DCBR_AW-1:0] rd_location;
		logic               rd_port_enable;
		logic               rd_clock_gate;
	} dcbr_rd_req_t;

endpackage : dcbr_pkg

// *** core/dcbr_edge.sv ***
// dcbr_edge: brings a port clock pin into clk_in, picks its rising or
// falling edge, and delays the port's bus by the same two stages.
// assumes: port clock far slower than clk_in; bus stable around edges.
`timescale 1ns/1ps
`default_nettype none
module dcbr_edge
	import dcbr_pkg::*;
#(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	// port clock pin and edge choice
	input  wire logic         port_clk_in,
	input  wire logic         fall_in,
	// port bus
	input  wire logic [W-1:0] bus_in,
	// aligned outputs
	output logic              strobe_out,
	output logic      [W-1:0] bus_out
);

	logic         clk_s1;
	logic         clk_s2;
	logic         clk_s3;
	logic [W-1:0] bus_d1;

	////////////////////////////////////////////////////////////////////
	// two-stage synchroniser, a history stage, matching bus delay
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			clk_s1  <= DCBR_BIT_RST;
			clk_s2  <= DCBR_BIT_RST;
			clk_s3  <= DCBR_BIT_RST;
			bus_d1  <= '0;
			bus_out <= '0;
		end else begin
			clk_s1  <= port_clk_in;
			clk_s2  <= clk_s1;
			clk_s3  <= clk_s2;
			bus_d1  <= bus_in;
			bus_out <= bus_d1;
		end
	end

	// edge select: first stage is never looked at here
	wire rise_seen = clk_s2 & ~clk_s3;
	wire fall_seen = ~clk_s2 & clk_s3;
	assign strobe_out = fall_in ? fall_seen : rise_seen;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	edge_single_pulse_a: assert property (
		strobe_out |=> !strobe_out)
		else $error("port edge strobe longer than one cycle");

	edge_polarity_a: assert property (
		$rose(strobe_out) && !fall_in |-> $past(!clk_s2) && clk_s2)
		else $error("rising edge strobe without a rising clock");

endmodule : dcbr_edge
`default_nettype wire

// *** core/dcbr_capture.sv ***
// dcbr_capture: the input register in front of the array; takes its
// bus on a qualified port edge and flags a fresh value for one cycle.
// assumes: take_in is a one-cycle pulse on clk_in.
`timescale 1ns/1ps
`default_nettype none
module dcbr_capture
	import dcbr_pkg::*;
#(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	// capture request
	input  wire logic         take_in,
	input  wire logic [W-1:0] d_in,
	// registered value
	output logic      [W-1:0] q_out,
	output logic              new_out
);

	////////////////////////////////////////////////////////////////////
	// input register and fresh flag
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			q_out   <= '0;
			new_out <= DCBR_BIT_RST;
		end else begin
			new_out <= take_in;
			if (take_in) begin
				q_out <= d_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	cap_load_a: assert property (
		take_in |=> (q_out == $past(d_in)) && new_out)
		else $error("input register missed a qualified edge");

	cap_hold_a: assert property (
		!take_in |=> $stable(q_out) && !new_out)
		else $error("input register changed without an edge");

endmodule : dcbr_capture
`default_nettype wire

// *** core/dcbr_ram.sv ***
// dcbr_ram: two-port block memory, 256 words of 16 bits, with a
// masked write port, a read port and a configuration preload port.
// assumes: port clocks arrive as pins and are sampled on clk_in;
// configuration logic and user fabric run on clk_in.
`timescale 1ns/1ps
`default_nettype none
module dcbr_ram
	import dcbr_pkg::*;
(
	// clock and reset
	input  wire logic               clk_in,
	input  wire logic               reset_in,
	// write port
	input  wire logic               wr_clk_pin_in,
	input  wire logic               wr_fall_edge_in,
	input  wire logic [DCBR_AW-1:0] wr_location_in,
	input  wire logic [DCBR_DW-1:0] wr_data_in,
	input  wire logic [DCBR_DW-1:0] wr_mask_in,
	input  wire logic               wr_port_enable_in,
	input  wire logic               wr_clock_gate_in,
	// read port
	input  wire logic               rd_clk_pin_in,
	input  wire logic               rd_fall_edge_in,
	input  wire logic [DCBR_AW-1:0] rd_location_in,
	input  wire logic               rd_port_enable_in,
	input  wire logic               rd_clock_gate_in,
	// configuration preload
	input  wire logic               cfg_active_in,
	input  wire logic               cfg_load_in,
	input  wire logic [DCBR_AW-1:0] cfg_location_in,
	input  wire logic [DCBR_DW-1:0] cfg_data_in,
	// read data
	output logic      [DCBR_DW-1:0] rd_data_out,
	output logic                    rd_valid_out
);

	////////////////////////////////////////////////////////////////////
	// declarations

	// storage array, no reset of contents
	logic [DCBR_DW-1:0] mem [DCBR_DEPTH];

	dcbr_wr_req_t       wr_req;
	dcbr_wr_req_t       wr_al;
	dcbr_wr_req_t       wr_cap;
	dcbr_rd_req_t       rd_req;
	dcbr_rd_req_t       rd_al;
	dcbr_rd_req_t       rd_cap;
	logic               wr_strobe;
	logic               rd_strobe;
	logic               wr_new;
	logic               rd_new;
	logic [DCBR_DW-1:0] wr_old;
	logic [DCBR_DW-1:0] wr_merged;
	logic [DCBR_DW-1:0] rd_word;

	////////////////////////////////////////////////////////////////////
	// pack the port buses into their carriers

	// write request as seen at the pins
	assign wr_req.wr_location    = wr_location_in;
	assign wr_req.wr_data        = wr_data_in;
	assign wr_req.wr_mask        = wr_mask_in;
	assign wr_req.wr_port_enable = wr_port_enable_in;
	assign wr_req.wr_clock_gate  = wr_clock_gate_in;

	// read request as seen at the pins
	assign rd_req.rd_location    = rd_location_in;
	assign rd_req.rd_port_enable = rd_port_enable_in;
	assign rd_req.rd_clock_gate  = rd_clock_gate_in;

	////////////////////////////////////////////////////////////////////
	// write port: edge pick, qualification, input register

	// timing of one write edge: the pin changes just after edge k,
	// stage one takes it at k+1 and stage two at k+2, which raises the
	// strobe; the input register loads at k+3 and the word changes at
	// k+4; the bus rides the same two stages, so it has to stand from
	// one cycle before the pin edge until two cycles after it

	// write clock pin, edge choice and aligned bus
	dcbr_edge #(
		.W          ($bits(dcbr_wr_req_t))
	) u_wr_edge (
		.clk_in     (clk_in),
		.reset_in   (reset_in),
		.port_clk_in(wr_clk_pin_in),
		.fall_in    (wr_fall_edge_in),
		.bus_in     (wr_req),
		.strobe_out (wr_strobe),
		.bus_out    (wr_al)
	);

	// edge counts only with both enables and outside configuration
	wire wr_take = wr_strobe
		& wr_al.wr_port_enable
		& wr_al.wr_clock_gate
		& ~cfg_active_in;

	// input register for location, data and mask
	dcbr_capture #(
		.W       ($bits(dcbr_wr_req_t))
	) u_wr_cap (
		.clk_in  (clk_in),
		.reset_in(reset_in),
		.take_in (wr_take),
		.d_in    (wr_al),
		.q_out   (wr_cap),
		.new_out (wr_new)
	);

	////////////////////////////////////////////////////////////////////
	// read port: edge pick, qualification, input register

	// same two-stage path as the write side, on its own pin, so the
	// two ports never share an edge and may run at unrelated rates

	// read clock pin, edge choice and aligned bus
	dcbr_edge #(
		.W          ($bits(dcbr_rd_req_t))
	) u_rd_edge (
		.clk_in     (clk_in),
		.reset_in   (reset_in),
		.port_clk_in(rd_clk_pin_in),
		.fall_in    (rd_fall_edge_in),
		.bus_in     (rd_req),
		.strobe_out (rd_strobe),
		.bus_out    (rd_al)
	);

	// read launched only with both read enables set
	wire rd_take = rd_strobe
		& rd_al.rd_port_enable
		& rd_al.rd_clock_gate;

	// input register for the read location
	dcbr_capture #(
		.W       ($bits(dcbr_rd_req_t))
	) u_rd_cap (
		.clk_in  (clk_in),
		.reset_in(reset_in),
		.take_in (rd_take),
		.d_in    (rd_al),
		.q_out   (rd_cap),
		.new_out (rd_new)
	);

	////////////////////////////////////////////////////////////////////
	// array access decode

	// preload is refused for location zero
	wire cfg_load_ok = cfg_active_in
		& cfg_load_in
		& (cfg_location_in != DCBR_NO_INIT_LOC);

	// word under the registered write location
	assign wr_old  = mem[wr_cap.wr_location];

	// word under the registered read location
	assign rd_word = mem[rd_cap.rd_location];

	// per-bit merge of new data with the stored word
	genvar b;
	generate
		for (b = 0; b < DCBR_DW; b++) begin : g_mask
			assign wr_merged[b] = wr_cap.wr_mask[b] ?
				wr_old[b] : wr_cap.wr_data[b];
		end
	endgenerate

	// user write happens one cycle after the input register loads
	wire wr_do = wr_new & ~cfg_load_ok;

	////////////////////////////////////////////////////////////////////
	// storage array update, preload first

	always_ff @(posedge clk_in) begin
		if (cfg_load_ok) begin
			mem[cfg_location_in] <= cfg_data_in;
		end else if (wr_do) begin
			mem[wr_cap.wr_location] <= wr_merged;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read data register; reads old word on a same-cycle write

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_data_out  <= DCBR_RD_DATA_RST;
			rd_valid_out <= DCBR_BIT_RST;
		end else begin
			rd_valid_out <= rd_new;
			if (rd_new) begin
				rd_data_out <= rd_word;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	// rd_path_a follows one qualified edge through the input register and then
	// the read register, one cycle each, and the wr_do checks a registered write into the array; words
	// never written hold unknowns, so array words are compared with
	// case equality and never with a plain equality

	wr_merge_a: assert property (
		wr_do |=> mem[$past(wr_cap.wr_location)] === $past(wr_merged))
		else $error("masked write did not reach the array");

	wr_gate_a: assert property (
		wr_strobe && !(wr_al.wr_port_enable && wr_al.wr_clock_gate)
		|=> !wr_new ##1 !wr_new)
		else $error("write taken without both write enables");

	rd_gate_a: assert property (
		rd_strobe && !(rd_al.rd_port_enable && rd_al.rd_clock_gate)
		|=> !rd_new ##1 !rd_valid_out)
		else $error("read launched without both read enables");

	rd_path_a: assert property (
		rd_take |=> rd_new ##1
		(rd_valid_out && rd_data_out === $past(rd_word)))
		else $error("read data not the addressed word");

	rd_hold_a: assert property (
		!rd_new |=> $stable(rd_data_out) && !rd_valid_out)
		else $error("read data changed without a read");

	cfg_load_a: assert property (
		cfg_load_ok |=> mem[$past(cfg_location_in)] === $past(cfg_data_in))
		else $error("preload word not stored");

	cfg_block_a: assert property (
		cfg_active_in |=> !wr_new)
		else $error("user write taken during configuration");

	wr_latency_a: assert property (
		wr_take |=> wr_new ##1 !wr_new)
		else $error("write edge not registered in one cycle");

	rd_valid_pulse_a: assert property (
		rd_valid_out |=> !rd_valid_out)
		else $error("read valid longer than one cycle");

	rd_one_launch_a: assert property (
		rd_take |=> !rd_take)
		else $error("read launched twice for one edge");

	rd_refused_keep_a: assert property (
		rd_strobe && !rd_take
		|=> ##1 rd_data_out === $past(rd_data_out))
		else $error("refused read edge changed read data");

	wr_idle_keep_a: assert property (
		!wr_do && !cfg_load_ok
		|=> mem[$past(wr_cap.wr_location)] === $past(wr_old))
		else $error("array word changed without a write");

	wr_one_word_a: assert property (
		wr_do |=> mem[$past(wr_cap.wr_location) ^ 8'h01]
		=== $past(mem[wr_cap.wr_location ^ 8'h01]))
		else $error("write disturbed a neighbouring word");

	wr_mask_keep_a: assert property (
		wr_do |=>
		(mem[$past(wr_cap.wr_location)] & $past(wr_cap.wr_mask))
		=== ($past(wr_old) & $past(wr_cap.wr_mask)))
		else $error("masked bit of the word was overwritten");

	wr_data_land_a: assert property (
		wr_do |=>
		(mem[$past(wr_cap.wr_location)] | $past(wr_cap.wr_mask))
		=== ($past(wr_cap.wr_data) | $past(wr_cap.wr_mask)))
		else $error("open bit of the word missed its data");

	cfg_zero_keep_a: assert property (
		cfg_active_in && cfg_load_in
		&& (cfg_location_in == DCBR_NO_INIT_LOC)
		&& !(wr_do && (wr_cap.wr_location == DCBR_NO_INIT_LOC))
		|=> mem[DCBR_NO_INIT_LOC] === $past(mem[DCBR_NO_INIT_LOC]))
		else $error("preload reached location zero");

endmodule : dcbr_ram
`default_nettype wire

// *** bench/dcbr_fabric.sv ***
// dcbr_fabric: user fabric model driving the write and read ports.
// assumes: tasks are called just after a clk_in edge; pins idle low.
`timescale 1ns/1ps
`default_nettype none
module dcbr_fabric
	import dcbr_pkg::*;
(
	// clock
	input  wire logic     clk_in,
	// port pins and requests
	output var logic      wr_pin_out,
	output var dcbr_wr_req_t wr_out,
	output var logic      rd_pin_out,
	output var dcbr_rd_req_t rd_out
);
	////////////////////////////////////////////////////////////////////
	// idle: pins low, write controls low so the array stays read-only
	initial begin
		wr_pin_out = 1'h0;
		rd_pin_out = 1'h0;
		wr_out = '0;
		rd_out = '0;
	end

	// one write edge pair; bus held around both edges, then released
	task automatic wr(input dcbr_wr_req_t r);
		wr_out <= r;
		@(posedge clk_in);
		wr_pin_out <= ~wr_pin_out;
		repeat (4) @(posedge clk_in);
		wr_pin_out <= ~wr_pin_out;
		repeat (6) @(posedge clk_in);
		wr_out <= {~r.wr_location, ~r.wr_data, ~r.wr_mask, 2'h0};
		@(posedge clk_in);
	endtask : wr

	// one read edge pair; same holding as the write side
	task automatic rd(input dcbr_rd_req_t r);
		rd_out <= r;
		@(posedge clk_in);
		rd_pin_out <= ~rd_pin_out;
		repeat (4) @(posedge clk_in);
		rd_pin_out <= ~rd_pin_out;
		repeat (6) @(posedge clk_in);
		rd_out <= {~r.rd_location, 2'h0};
		@(posedge clk_in);
	endtask : rd
endmodule : dcbr_fabric
`default_nettype wire

// *** bench/dcbr_ram_bench.sv ***
// dcbr_ram_bench: self-checking bench with a word-array model.
// assumes: dcbr_pkg compiled first; one clk_in domain.
`timescale 1ns/1ps
`default_nettype none
module dcbr_ram_bench
	import dcbr_pkg::*;
;
	logic               clk_in, reset_in, wr_fall, rd_fall;
	logic               cfg_active, cfg_load, rd_valid, wr_pin, rd_pin;
	logic [DCBR_AW-1:0] cfg_location;
	logic [DCBR_DW-1:0] cfg_data, rd_data, got_d;
	dcbr_wr_req_t       fab_wr, wq;
	dcbr_rd_req_t       fab_rd, rq;
	logic [DCBR_DW-1:0] mem [DCBR_DEPTH];
	int                 fail_count, checks, got_n, seed, j;

	////////////////////////////////////////////////////////////////////
	// design and fabric partner; one block covers all 256 words, so
	// the fabric needs no outside location decode or data mux
	dcbr_ram u_dut (.clk_in(clk_in), .reset_in(reset_in),
		.wr_clk_pin_in(wr_pin), .wr_fall_edge_in(wr_fall),
		.wr_location_in(fab_wr.wr_location), .wr_data_in(fab_wr.wr_data),
		.wr_mask_in(fab_wr.wr_mask),
		.wr_port_enable_in(fab_wr.wr_port_enable),
		.wr_clock_gate_in(fab_wr.wr_clock_gate),
		.rd_clk_pin_in(rd_pin), .rd_fall_edge_in(rd_fall),
		.rd_location_in(fab_rd.rd_location),
		.rd_port_enable_in(fab_rd.rd_port_enable),
		.rd_clock_gate_in(fab_rd.rd_clock_gate),
		.cfg_active_in(cfg_active), .cfg_load_in(cfg_load),
		.cfg_location_in(cfg_location), .cfg_data_in(cfg_data),
		.rd_data_out(rd_data), .rd_valid_out(rd_valid));
	dcbr_fabric u_fab (.clk_in(clk_in), .wr_pin_out(wr_pin),
		.wr_out(fab_wr), .rd_pin_out(rd_pin), .rd_out(fab_rd));

	// clock and read-result monitor
	initial begin
		clk_in = 1'h0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (rd_valid === 1'h1) begin
			got_n++;
			got_d = rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [DCBR_DW-1:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic results;
		if (fail_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results

	// reset pulse; outputs cleared, contents kept in the model
	task automatic do_reset;
		reset_in <= 1'h1;
		repeat (5) @(posedge clk_in);
		check(rd_data, DCBR_RD_DATA_RST);
		check(16'(rd_valid), 16'h0000);
		reset_in <= 1'h0;
		got_d = DCBR_RD_DATA_RST;
		repeat (4) @(posedge clk_in);
	endtask : do_reset

	// one write and one read launched together on separate clocks
	task automatic step(input dcbr_wr_req_t w, input dcbr_rd_req_t r);
		logic [DCBR_DW-1:0] e;
		int n;
		e = mem[r.rd_location];
		n = got_n;
		fork
			u_fab.wr(w);
			u_fab.rd(r);
		join
		if (w.wr_port_enable && w.wr_clock_gate && !cfg_active)
			mem[w.wr_location] = (mem[w.wr_location] & w.wr_mask)
				| (w.wr_data & ~w.wr_mask);
		if (r.rd_port_enable && r.rd_clock_gate) begin
			check(16'(got_n - n), 16'h0001);
			if (!$isunknown(e)) check(got_d, e);
		end else begin
			check(16'(got_n - n), 16'h0000);
			check(rd_data, got_d);
		end
	endtask : step

	// random traffic; first nine steps fill locations 0..7 and FF whole
	task automatic run(input int cnt);
		for (int i = 0; i < cnt; i++) begin
			wq = 42'({$random(seed), $random(seed)});
			rq = 10'($random(seed));
			wq.wr_location = (i % 7 == 0) ? 8'hFF : wq.wr_location & 8'h07;
			rq.rd_location = (i % 6 == 0) ? 8'hFF : rq.rd_location & 8'h07;
			if (i < 9) wq.wr_location = (i == 8) ? 8'hFF : 8'(i);
			if (i < 9 || i % 3 == 0) wq.wr_mask = 16'h0000;
			wq.wr_clock_gate = (i % 4 != 3);
			wq.wr_port_enable = (i % 5 != 4);
			rq.rd_clock_gate = (i % 4 != 1);
			rq.rd_port_enable = (i % 5 != 2);
			if (i < 9) wq.wr_clock_gate = 1'h1;
			if (i < 9) wq.wr_port_enable = 1'h1;
			if (rq.rd_location == wq.wr_location)
				rq.rd_location ^= 8'h01;
			step(wq, rq);
		end
	endtask : run

	////////////////////////////////////////////////////////////////////
	initial begin
		{wr_fall, rd_fall, cfg_active, cfg_load} = 4'h0;
		{cfg_location, cfg_data} = '0;
		{fail_count, checks, got_n} = '0;
		seed = 50509;
		reset_in = 1'h1;
		do_reset();
		// preload, location 0 among them, then a refused user write
		cfg_active <= 1'h1;
		for (j = 0; j < 5; j++) begin
			cfg_load <= 1'h1;
			cfg_location <= (j == 0) ? 8'h00 : 8'(8'h20 + j);
			cfg_data <= 16'($random(seed));
			@(posedge clk_in);
			if (j > 0) mem[8'h20 + j] = cfg_data;
		end
		cfg_load <= 1'h0;
		step({8'h21, 16'h5A5A, 16'h0000, 2'h3}, {8'h22, 2'h3});
		cfg_active <= 1'h0;
		// read-only use of preloaded words
		for (j = 1; j < 5; j++)
			step('0, {8'(8'h20 + j), 2'h3});
		run(40);
		do_reset();
		wr_fall <= 1'h1;
		rd_fall <= 1'h1;
		repeat (3) @(posedge clk_in);
		run(30);
		results();
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge clk_in);
		fail_count++;
		results();
	end
endmodule : dcbr_ram_bench
`default_nettype wire
